// ### src/aau_unit.sv
// Accumulator slice: absolute value, absolute with test-flag toggle,
// shifted immediate add and register-shifted memory add with repeat.
// Assumes the decoder holds off new opcodes while op_busy is high and
// the operand fetch presents a fresh mem_operand on every repeat cycle.
//
// Added by the designer: the register addresses and strobed register access.
`default_nettype none

module aau_unit
   import aau_pkg::*;
(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // Register port
   input  wire logic [3:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [31:0]      reg_rdata,
   // Instruction issue from decoder
   input  wire logic             op_valid,
   input  wire logic [15:0]      op_word,
   input  wire logic [15:0]      op_ext_word,
   input  wire logic             rpt_valid,
   input  wire logic [RPT_W-1:0] rpt_count,
   // Operand fetch
   input  wire logic [15:0]      mem_operand,
   // Status to decoder
   output logic                  op_busy,
   output logic                  op_done,
   output logic                  op_illegal
);

   // Architectural state
   logic [31:0]      main_sum_register_reg;
   logic [31:0]      main_sum_register_next;
   logic [31:0]      multiplicand_register_reg;
   logic [31:0]      multiplicand_register_next;
   logic [OVF_W-1:0] overflow_counter_reg;
   logic [OVF_W-1:0] overflow_counter_next;
   logic [RPT_W-1:0] repeat_counter_reg;
   logic [RPT_W-1:0] repeat_counter_next;
   logic [2:0]       mode_reg;
   logic [2:0]       mode_next;
   logic             flag_n_reg;
   logic             flag_n_next;
   logic             flag_z_reg;
   logic             flag_z_next;
   logic             flag_c_reg;
   logic             flag_c_next;
   logic             flag_v_reg;
   logic             flag_v_next;
   logic             test_flag_reg;
   logic             test_flag_next;
   aau_state_t       state_reg;
   aau_state_t       state_next;
   logic [31:0]      rdata_next;
   logic             done_next;
   logic             illegal_next;

   // Mode bits
   logic saturation_mode;
   logic sign_extension_mode;
   logic object_mode;
   assign saturation_mode     = mode_reg[MODE_SAT];
   assign sign_extension_mode = mode_reg[MODE_SGN];
   assign object_mode         = mode_reg[MODE_OBJ];

   // Register port decode
   logic wr_mode;
   logic wr_acc;
   logic wr_mul;
   logic wr_ovf;
   logic wr_status;
   assign wr_mode   = reg_wr && (reg_addr == REG_MODE);
   assign wr_acc    = reg_wr && (reg_addr == REG_ACC);
   assign wr_mul    = reg_wr && (reg_addr == REG_MUL);
   assign wr_ovf    = reg_wr && (reg_addr == REG_OVF);
   assign wr_status = reg_wr && (reg_addr == REG_STATUS);

   // Instruction decode and acceptance
   aau_op_t op_kind;
   logic    start;
   logic    in_rpt;
   logic    legal;
   logic    rpt_start;
   logic    rpt_last;
   assign op_kind   = aau_decode(op_word);
   assign start     = op_valid && (state_reg == AAU_ST_IDLE);
   assign in_rpt    = (state_reg == AAU_ST_RPT);
   assign legal     = (op_kind == AAU_OP_ABS) || (op_kind == AAU_OP_ADDIMM) ||
                      (((op_kind == AAU_OP_ABSTG) || (op_kind == AAU_OP_ADDT))
                       && object_mode);
   assign rpt_start = start && legal && (op_kind == AAU_OP_ADDT) && rpt_valid &&
                      (rpt_count != RPT_ZERO);
   assign rpt_last  = in_rpt && (repeat_counter_reg == RPT_ONE);

   // Execution strobes
   logic exec_abs;
   logic exec_abstg;
   logic exec_imm;
   logic exec_addt;
   logic exec_absany;
   logic exec_add;
   assign exec_abs    = start && legal && (op_kind == AAU_OP_ABS);
   assign exec_abstg  = start && legal && (op_kind == AAU_OP_ABSTG);
   assign exec_imm    = start && legal && (op_kind == AAU_OP_ADDIMM);
   assign exec_addt   = (start && legal && (op_kind == AAU_OP_ADDT)) || in_rpt;
   assign exec_absany = exec_abs || exec_abstg;
   assign exec_add    = exec_imm || exec_addt;

   // Operand selection: immediate word with its shift field, or memory
   // operand shifted by the multiplicand upper half
   logic [15:0]        add_operand;
   logic [SHIFT_W-1:0] shift_field;
   logic [31:0]        addend;
   assign add_operand = exec_imm ? op_ext_word : mem_operand;
   assign shift_field = exec_imm ? op_word[SHIFT_W-1:0]
                       : multiplicand_register_reg[HI_SHIFT_LSB +: SHIFT_W];

   aau_operand_shift u_shift (
      .operand             (add_operand),
      .shift               (shift_field),
      .sign_extension_mode (sign_extension_mode),
      .shifted             (addend)
   );

   // Adder with signed overflow detection
   logic [32:0] sum_wide;
   logic [31:0] add_raw;
   logic        add_carry;
   logic        ovf_pos;
   logic        ovf_neg;
   logic [31:0] add_result;
   assign sum_wide   = {1'b0, main_sum_register_reg} + {1'b0, addend};
   assign add_raw    = sum_wide[31:0];
   assign add_carry  = sum_wide[32];
   assign ovf_pos    = exec_add && !main_sum_register_reg[31] && !addend[31] &&
                       add_raw[31];
   assign ovf_neg    = exec_add && main_sum_register_reg[31] && addend[31] &&
                       !add_raw[31];
   assign add_result = !saturation_mode ? add_raw :
                       ovf_pos ? ACC_MAX : ovf_neg ? ACC_MIN : add_raw;

   // Absolute value with most-negative special case
   logic        acc_is_min;
   logic        acc_is_neg;
   logic [31:0] abs_result;
   assign acc_is_min = (main_sum_register_reg == ACC_MIN);
   assign acc_is_neg = main_sum_register_reg[31];
   assign abs_result = acc_is_min ? (saturation_mode ? ACC_MAX : ACC_MIN) :
                       acc_is_neg ? (ACC_ZERO - main_sum_register_reg)
                                  : main_sum_register_reg;

   // Accumulator and multiplicand, execution wins over a software write
   assign main_sum_register_next = exec_absany ? abs_result :
                                   exec_add ? add_result :
                                   wr_acc ? reg_wdata : main_sum_register_reg;
   assign multiplicand_register_next = wr_mul ? reg_wdata : multiplicand_register_reg;
   assign mode_next = wr_mode ? reg_wdata[2:0] : mode_reg;

   // Result flags; each executing step refreshes N and Z from its own result, C from the adder carry (abs clears it), V only sets and TF only toggles
   logic exec_any;
   logic [31:0] status_base;
   assign exec_any    = exec_absany || exec_add;
   assign status_base = wr_status ? reg_wdata
                        : {27'h0, test_flag_reg, flag_v_reg, flag_c_reg,
                           flag_z_reg, flag_n_reg};
   assign flag_n_next = exec_any ? main_sum_register_next[31]
                        : status_base[ST_N];
   assign flag_z_next = exec_any ? (main_sum_register_next == ACC_ZERO)
                        : status_base[ST_Z];
   assign flag_c_next = exec_absany ? 1'b0 :
                        exec_add ? add_carry : status_base[ST_C];
   // Overflow is sticky: set wins over a same-cycle software clear
   assign flag_v_next = status_base[ST_V] || (exec_absany && acc_is_min) ||
                        ovf_pos || ovf_neg;
   assign test_flag_next = status_base[ST_TF] ^
                           (exec_abstg && acc_is_neg);

   // Overflow counter counts only when saturation is off
   assign overflow_counter_next =
      (ovf_pos && !saturation_mode) ? overflow_counter_reg + OVF_ONE :
      (ovf_neg && !saturation_mode) ? overflow_counter_reg - OVF_ONE :
      wr_ovf ? reg_wdata[OVF_W-1:0] : overflow_counter_reg;

   // Repeat counter and sequencing
   assign repeat_counter_next = rpt_start ? rpt_count :
                                in_rpt ? repeat_counter_reg - RPT_ONE :
                                (start && legal) ? RPT_ZERO :
                                repeat_counter_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         AAU_ST_IDLE: begin
            if (rpt_start) state_next = AAU_ST_RPT;
         end
         AAU_ST_RPT: begin
            if (rpt_last) state_next = AAU_ST_IDLE;
         end
      endcase
   end

   // Handshake outputs
   assign done_next    = (start && legal && !rpt_start) || rpt_last;
   assign illegal_next = start && !legal;

   // Read data mux, unmapped addresses read zero
   always_comb begin
      rdata_next = WORD_RST;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_MODE:   rdata_next = {29'h0, mode_reg};
            REG_ACC:    rdata_next = main_sum_register_reg;
            REG_MUL:    rdata_next = multiplicand_register_reg;
            REG_OVF:    rdata_next = {{(32-OVF_W){overflow_counter_reg[OVF_W-1]}},
                                      overflow_counter_reg};
            REG_STATUS: rdata_next = {27'h0, test_flag_reg, flag_v_reg, flag_c_reg,
                                      flag_z_reg, flag_n_reg};
            REG_RPTN:   rdata_next = {24'h0, repeat_counter_reg};
            default:    rdata_next = WORD_RST;
         endcase
      end
   end

   // Datapath registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         main_sum_register_reg     <= WORD_RST;
         multiplicand_register_reg <= WORD_RST;
         overflow_counter_reg      <= '0;
         mode_reg                  <= MODE_RST;
      end else begin
         main_sum_register_reg     <= main_sum_register_next;
         multiplicand_register_reg <= multiplicand_register_next;
         overflow_counter_reg      <= overflow_counter_next;
         mode_reg                  <= mode_next;
      end
   end

   // Flag registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flag_n_reg    <= 1'b0;
         flag_z_reg    <= 1'b0;
         flag_c_reg    <= 1'b0;
         flag_v_reg    <= 1'b0;
         test_flag_reg <= 1'b0;
      end else begin
         flag_n_reg    <= flag_n_next;
         flag_z_reg    <= flag_z_next;
         flag_c_reg    <= flag_c_next;
         flag_v_reg    <= flag_v_next;
         test_flag_reg <= test_flag_next;
      end
   end

   // Sequencer and outputs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg          <= AAU_ST_IDLE;
         repeat_counter_reg <= RPT_ZERO;
         reg_rdata          <= WORD_RST;
         op_busy            <= 1'b0;
         op_done            <= 1'b0;
         op_illegal         <= 1'b0;
      end else begin
         state_reg          <= state_next;
         repeat_counter_reg <= repeat_counter_next;
         reg_rdata          <= rdata_next;
         op_busy            <= (state_next == AAU_ST_RPT);
         op_done            <= done_next;
         op_illegal         <= illegal_next;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_abs_negates: assert property (exec_abs && acc_is_neg && !acc_is_min |=>
      main_sum_register_reg == ACC_ZERO - $past(main_sum_register_reg))
      else $error("abs did not negate");
   a_abs_min_sat: assert property (exec_absany && acc_is_min |=> flag_v_reg &&
      main_sum_register_reg == ($past(saturation_mode) ? ACC_MAX : ACC_MIN))
      else $error("abs of most negative wrong");
   a_abs_flags: assert property (exec_absany |=> !flag_c_reg &&
      flag_n_reg == main_sum_register_reg[31] &&
      flag_z_reg == (main_sum_register_reg == ACC_ZERO))
      else $error("abs flags wrong");
   a_nonrpt_clear: assert property (start && legal && !rpt_start |=>
      repeat_counter_reg == RPT_ZERO && !op_busy && op_done)
      else $error("single op did not clear repeat");
   a_objmode_gate: assert property (start && !object_mode && !wr_acc &&
      (op_kind == AAU_OP_ABSTG || op_kind == AAU_OP_ADDT) |=> op_illegal &&
      $stable(main_sum_register_reg))
      else $error("object mode gate failed");
   a_tf_toggle: assert property (exec_abstg && !wr_status |=>
      test_flag_reg == ($past(test_flag_reg) ^ $past(main_sum_register_reg[31])))
      else $error("test flag toggle wrong");
   a_add_clamp: assert property (exec_add && saturation_mode && ovf_pos |=>
      main_sum_register_reg == ACC_MAX && flag_v_reg)
      else $error("positive clamp missing");
   a_add_clamp_neg: assert property (exec_add && saturation_mode && ovf_neg |=>
      main_sum_register_reg == ACC_MIN && flag_v_reg)
      else $error("negative clamp missing");
   a_add_flags: assert property (exec_add |=>
      flag_n_reg == main_sum_register_reg[31] &&
      flag_z_reg == (main_sum_register_reg == ACC_ZERO))
      else $error("add flags wrong");
   a_ovf_count: assert property (ovf_neg && !saturation_mode |=>
      overflow_counter_reg == $past(overflow_counter_reg) - OVF_ONE)
      else $error("overflow counter not decremented");
   a_ovf_hold_sat: assert property (exec_add && saturation_mode && !wr_ovf |=>
      $stable(overflow_counter_reg))
      else $error("overflow counter moved under saturation");
   a_v_sticky: assert property (flag_v_reg && !wr_status |=> flag_v_reg)
      else $error("overflow flag dropped");
   a_rpt_length: assert property (rpt_start && rpt_count == 8'h06 |=>
      op_busy [*6] ##1 (!op_busy && op_done))
      else $error("repeat length wrong");

   c_abs_min:  cover property (exec_abs && acc_is_min);
   c_abstg:    cover property (exec_abstg && acc_is_neg);
   c_imm_ovf:  cover property (exec_imm && ovf_pos);
   c_rpt_done: cover property (rpt_last);

endmodule // aau_unit

`default_nettype wire

// ### src/aau_pkg.sv
// Constants, opcode encodings and types shared by the accumulator unit.
// Assumes one core clock and a synchronous active-high reset.
`default_nettype none

package aau_pkg;

   // Opcode words decoded by the unit
   localparam logic [15:0] OPC_ABS       = 16'hFF56;
   localparam logic [15:0] OPC_ABSTG     = 16'h565F;
   localparam logic [15:0] OPC_ADDT      = 16'h5623;
   localparam logic [15:0] OPC_ADDIMM    = 16'hFF10;
   localparam logic [15:0] OPC_ADDIMM_MK = 16'hFFF0;

   // Datapath values
   localparam logic [31:0] ACC_MAX  = 32'h7FFFFFFF;
   localparam logic [31:0] ACC_MIN  = 32'h80000000;
   localparam logic [31:0] ACC_ZERO = 32'h00000000;
   localparam int          SHIFT_W  = 4;
   localparam int          HI_SHIFT_LSB = 16;
   localparam int          OVF_W    = 6;
   localparam int          RPT_W    = 8;
   localparam logic [OVF_W-1:0] OVF_ONE = 6'h01;
   localparam logic [RPT_W-1:0] RPT_ONE = 8'h01;
   localparam logic [RPT_W-1:0] RPT_ZERO = 8'h00;

   // Register word addresses
   localparam logic [3:0] REG_MODE   = 4'h0;
   localparam logic [3:0] REG_ACC    = 4'h1;
   localparam logic [3:0] REG_MUL    = 4'h2;
   localparam logic [3:0] REG_OVF    = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RPTN   = 4'h5;

   // Field positions
   localparam int MODE_SAT = 0;
   localparam int MODE_SGN = 1;
   localparam int MODE_OBJ = 2;
   localparam int ST_N  = 0;
   localparam int ST_Z  = 1;
   localparam int ST_C  = 2;
   localparam int ST_V  = 3;
   localparam int ST_TF = 4;

   // Reset values
   localparam logic [2:0]  MODE_RST = 3'h4;
   localparam logic [31:0] WORD_RST = 32'h00000000;

   typedef enum logic [2:0] {
      AAU_OP_NONE, AAU_OP_ABS, AAU_OP_ABSTG, AAU_OP_ADDIMM, AAU_OP_ADDT
   } aau_op_t;

   typedef enum logic {AAU_ST_IDLE, AAU_ST_RPT} aau_state_t;

   // Opcode word to operation kind
   function automatic aau_op_t aau_decode(input logic [15:0] w);
      aau_op_t k;
      k = AAU_OP_NONE;
      if (w == OPC_ABS) k = AAU_OP_ABS;
      else if (w == OPC_ABSTG) k = AAU_OP_ABSTG;
      else if (w == OPC_ADDT) k = AAU_OP_ADDT;
      else if ((w & OPC_ADDIMM_MK) == OPC_ADDIMM) k = AAU_OP_ADDIMM;
      return k;
   endfunction

endpackage

`default_nettype wire

// ### src/aau_operand_shift.sv
// Extends a 16-bit operand to 32 bits and shifts it left.
// Assumes the shift amount is already limited to 0..15.
`default_nettype none

module aau_operand_shift
   import aau_pkg::*;
(
   // Operand in
   input  wire logic [15:0]        operand,
   input  wire logic [SHIFT_W-1:0] shift,
   input  wire logic               sign_extension_mode,
   // Result
   output logic      [31:0]        shifted
);

   logic [31:0] extended;

   // Sign or zero extension, zeros enter from the bottom
   assign extended = sign_extension_mode ? {{16{operand[15]}}, operand}
                                         : {16'h0000, operand};
   assign shifted  = extended << shift;

endmodule // aau_operand_shift

`default_nettype wire

// ### verif/aau_fetch_model.sv
// Operand fetch model standing in front of the accumulator unit.
// Assumes the unit takes a request at an edge with op_valid high and
// op_busy low, and reads a fresh operand on every repeat cycle.
`default_nettype none

module aau_fetch_model
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Issue status from the bench and the unit
   input  wire logic        op_valid,
   input  wire logic        op_busy,
   input  wire logic [15:0] fetch_base,
   input  wire logic [15:0] fetch_step,
   // Operand bus
   output logic      [15:0] mem_operand
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [15:0] next_reg;
   wire  logic  issue_now;

   // Issue is only seen while the unit is idle
   assign issue_now = op_valid & ~op_busy;

   // Operand for the following repeat step
   always_ff @(posedge core_clk) begin
      if (rst) begin
         next_reg <= 16'h0000;
      end else if (issue_now | op_busy) begin
         next_reg <= mem_operand + fetch_step;
      end
   end

   // Outside a fetch the bus shows inverted stale data, never a valid word
   assign mem_operand = issue_now ? fetch_base : (op_busy ? next_reg : ~next_reg);
endmodule // aau_fetch_model

`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the accumulator unit with a reference model.
// Assumes the register map and opcodes of aau_pkg and one 10 MHz clock.
`default_nettype none

module testbench
   import aau_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // Stimulus and observation
   logic             core_clk;
   logic             rst = 1'b1;
   logic             reg_wr = 1'b0;
   logic             reg_rd = 1'b0;
   logic             op_valid = 1'b0;
   logic             rpt_valid = 1'b0;
   logic [3:0]       reg_addr = 4'h0;
   logic [31:0]      reg_wdata = 32'h00000000;
   logic [15:0]      op_word = 16'h0000;
   logic [15:0]      op_ext_word = 16'h0000;
   logic [15:0]      fetch_base = 16'h0000;
   logic [15:0]      fetch_step = 16'h0000;
   logic [RPT_W-1:0] rpt_count = 8'h00;
   logic [31:0]      reg_rdata;
   logic [15:0]      mem_operand;
   logic             op_busy, op_done, op_illegal;
   // Reference state
   logic [31:0]      m_acc = 32'h00000000;
   logic [31:0]      m_mul = 32'h00000000;
   logic [OVF_W-1:0] m_ovf = 6'h00;
   logic             m_n = 1'b0, m_z = 1'b0, m_c = 1'b0, m_v = 1'b0, m_tf = 1'b0;
   logic             m_sat = 1'b0, m_sgn = 1'b0, m_obj = 1'b1;
   int               bad_count = 0, checks_done = 0, cycles = 0;
   logic [31:0]      absv [5] = '{32'hFFFFFF00, 32'h00000005, ACC_ZERO, ACC_MIN, 32'h80000001};
   logic [RPT_W-1:0] rptn [3] = '{8'h00, 8'h01, 8'h06};

   aau_unit dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
      .op_word(op_word), .op_ext_word(op_ext_word), .rpt_valid(rpt_valid),
      .rpt_count(rpt_count), .mem_operand(mem_operand), .op_busy(op_busy),
      .op_done(op_done), .op_illegal(op_illegal));

   aau_fetch_model u_fetch (.core_clk(core_clk), .rst(rst), .op_valid(op_valid),
      .op_busy(op_busy), .fetch_base(fetch_base), .fetch_step(fetch_step),
      .mem_operand(mem_operand));

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Register port cycles
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk32(reg_rdata, exp);
   endtask

   task automatic wr_model(input logic [3:0] a, input logic [31:0] d);
      reg_write(a, d);
      if (a == REG_ACC) m_acc = d;
      if (a == REG_MUL) m_mul = d;
      if (a == REG_STATUS) {m_tf, m_v, m_c, m_z, m_n} = d[4:0];
   endtask

   task automatic set_mode(input logic sat, input logic sgn, input logic obj);
      m_sat = sat;
      m_sgn = sgn;
      m_obj = obj;
      reg_write(REG_MODE, {29'h0, obj, sgn, sat});
   endtask

   task automatic check_state();
      chk_reg(REG_ACC, m_acc);
      chk_reg(REG_STATUS, {27'h0, m_tf, m_v, m_c, m_z, m_n});
      chk_reg(REG_OVF, {{(32-OVF_W){m_ovf[OVF_W-1]}}, m_ovf});
      chk_reg(REG_RPTN, 32'h00000000);
   endtask

   // Reference arithmetic
   function automatic logic [31:0] ext16(input logic [15:0] v, input logic [3:0] sh);
      return {{16{m_sgn & v[15]}}, v} << sh;
   endfunction

   task automatic m_add(input logic [31:0] b);
      logic [32:0] s;
      s = {1'b0, m_acc} + {1'b0, b};
      m_c = s[32];
      if (m_acc[31] == b[31] && s[31] != b[31]) begin
         m_v = 1'b1;
         if (m_sat) s[31:0] = b[31] ? ACC_MIN : ACC_MAX;
         else m_ovf = b[31] ? m_ovf - OVF_ONE : m_ovf + OVF_ONE;
      end
      m_acc = s[31:0];
      m_n = m_acc[31];
      m_z = (m_acc == ACC_ZERO);
   endtask

   task automatic m_abs(input logic tog);
      if (m_acc[31]) begin
         m_tf = m_tf ^ tog;
         if (m_acc == ACC_MIN) begin
            m_v = 1'b1;
            if (m_sat) m_acc = ACC_MAX;
         end else m_acc = -m_acc;
      end
      m_c = 1'b0;
      m_n = m_acc[31];
      m_z = (m_acc == ACC_ZERO);
   endtask

   // Issue one instruction, time its completion and update the model
   task automatic do_op(input logic [15:0] w, input logic [15:0] ext, input logic rpt,
                        input logic [RPT_W-1:0] n);
      logic ill, addt, absk, immk;
      int   i, steps;
      addt = (w == OPC_ADDT);
      absk = (w == OPC_ABS) || (w == OPC_ABSTG);
      immk = ((w & OPC_ADDIMM_MK) == OPC_ADDIMM);
      ill = ~(immk | (w == OPC_ABS) | (m_obj & (addt | (w == OPC_ABSTG))));
      steps = (addt && rpt && !ill) ? int'(n) : 0;
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_word <= w;
      op_ext_word <= ext;
      rpt_valid <= rpt;
      rpt_count <= n;
      @(posedge core_clk);
      op_valid <= 1'b0;
      rpt_valid <= 1'b0;
      for (i = 0; i < 40; i++) begin
         #1 chk1(op_busy, i < steps);
         if (op_done === 1'b1 || op_illegal === 1'b1) break;
         @(posedge core_clk);
      end
      chk32(32'(i), 32'(steps));
      chk1(op_illegal, ill);
      if (!ill && absk) m_abs(w == OPC_ABSTG);
      else if (!ill && addt) begin
         for (i = 0; i <= steps; i++)
            m_add(ext16(fetch_base + 16'(i) * fetch_step, m_mul[HI_SHIFT_LSB +: SHIFT_W]));
      end else if (!ill) m_add(ext16(ext, w[3:0]));
   endtask

   // Main sequence
   initial begin
      int s, k;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      chk_reg(REG_MODE, {29'h0, MODE_RST});
      chk_reg(4'hF, WORD_RST);
      check_state();
      $display("test reset done");
      // Absolute value, plain and toggling, both saturation settings
      for (s = 0; s < 2; s++) begin
         set_mode(s[0], 1'b0, 1'b1);
         wr_model(REG_STATUS, 32'h00000010);
         foreach (absv[k]) begin
            wr_model(REG_ACC, absv[k]);
            do_op(OPC_ABS, 16'h0000, k[0], 8'h04);
            check_state();
            wr_model(REG_ACC, absv[k]);
            do_op(OPC_ABSTG, 16'h0000, k[1], 8'h07);
            check_state();
         end
      end
      $display("test absolute done");
      // Object mode 0 refuses the mode-1-only operations
      set_mode(1'b0, 1'b0, 1'b0);
      wr_model(REG_ACC, 32'h00001234);
      do_op(OPC_ABSTG, 16'h0000, 1'b0, 8'h00);
      do_op(OPC_ADDT, 16'h0000, 1'b1, 8'h02);
      do_op(16'h0000, 16'h0000, 1'b0, 8'h00);
      do_op(OPC_ADDIMM | 16'h0003, 16'h0101, 1'b0, 8'h00);
      check_state();
      $display("test object mode done");
      // Shifted immediate add over every shift and every saturation and sign-extension setting
      for (s = 0; s < 4; s++) begin
         set_mode(s[0], s[1], 1'b1);
         wr_model(REG_STATUS, 32'h00000000);
         wr_model(REG_ACC, s[1] ? 32'h80100000 : 32'h7FF00000);
         for (k = 0; k < 16; k++) begin
            do_op(OPC_ADDIMM | 16'(k), 16'h8A5C, k == 7, 8'h03);
            check_state();
         end
      end
      $display("test immediate add done");
      // Register-shifted add, repeated and single
      for (s = 0; s < 4; s++) begin
         set_mode(s[0], s[1], 1'b1);
         wr_model(REG_STATUS, 32'h00000000);
         wr_model(REG_MUL, s[1] ? 32'hABC31234 : 32'h000F0000);
         wr_model(REG_ACC, s[1] ? 32'h80010000 : 32'h7FF00000);
         fetch_base <= s[1] ? 16'h9001 : 16'h4001;
         fetch_step <= 16'h0111;
         foreach (rptn[k]) begin
            do_op(OPC_ADDT, 16'h0000, 1'b1, rptn[k]);
            check_state();
         end
         do_op(OPC_ADDT, 16'h0000, 1'b0, 8'h05);
         check_state();
      end
      $display("test shifted add done");
      end_sim();
   end
endmodule // testbench

`default_nettype wire
